/* rtl/swp_write_protect.sv */
// Purpose: status register write gate and pin/drive/scheme config
// Assumes: cmd* is a one-cycle decoded command from the serial front end
// Notes: non-volatile guard bits and lock bit arrive as static inputs
//
// Functional notes
// - guard 00: writes accepted when latch set
// - guard 01 and pin low: reject unless four-lane mode
// - guard 01 and pin high: accept with latch
// - guard 10: blocked until next reset
// - guard 11, lock 0: blocked until reset
// - guard 11, lock 1: blocked permanently
// - reset: non-volatile 00/01 copied unchanged
// - reset: non-volatile 10 gives 00
// - reset: 11 without lock gives 01
// - reset: 11 with lock keeps 11
// - config bit 7 picks pause or reset
// - four-lane mode disables pause and reset
// - strength field bits 6:5, default 01
// - config bit 2 picks range or block locks
// - all block locks set at any reset
// - four-lane mode makes guard pin data lane
// - high guard bit at status-2 bit 0
module swp_write_protect #(
	parameter int NUM = swp_pkg::NUM_BLOCKS,
	parameter int AW = $clog2(swp_pkg::NUM_BLOCKS)
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic devReset,
	input wire logic nvGuardHigh,
	input wire logic nvGuardLow,
	input wire logic permanentLockBit,
	input wire logic writeLatchFlag,
	input wire logic guardPin,
	input wire logic cmdValid,
	input wire logic [7:0] cmdOpcode,
	input wire logic [7:0] cmdData,
	input wire logic [AW-1:0] cmdBlock,
	output logic statusGuardHigh,
	output logic statusGuardLow,
	output logic fourLaneEnable,
	output logic [7:0] pinDriveProtectConfig,
	output logic [1:0] outputStrength,
	output logic protectSchemeSelect,
	output logic pauseEnable,
	output logic resetPinEnable,
	output logic writeAccepted,
	output logic writeRejected,
	output logic blockLockRead,
	output logic [NUM-1:0] blockLocks
);
	import swp_pkg::*;

	typedef struct packed {
		logic guardHigh;
		logic guardLow;
		logic fourLane;
		logic [7:0] cfg;
		logic accepted;
		logic rejected;
		logic loadPending;
	} swp_state_s;

	swp_state_s st;
	swp_state_s next_st;
	logic isStatusWrite;
	logic isBlockCmd;
	logic guardEff;
	logic writeAllowed;
	logic reload;

	////////////////////////////////////////////////////////////////////////
	// write gate
	assign isStatusWrite = cmdValid && (cmdOpcode == OP_WR_SR1 ||
		cmdOpcode == OP_WR_SR2 || cmdOpcode == OP_WR_SR3 ||
		cmdOpcode == OP_WR_SR4);
	assign isBlockCmd = cmdValid && st.cfg[CFG_SCHEME_BIT] &&
		(cmdOpcode == OP_BLK_LOCK || cmdOpcode == OP_BLK_UNLOCK);
	// pin reads high once it serves as a data lane
	assign guardEff = st.fourLane ? 1'b1 : guardPin;
	assign reload = st.loadPending || devReset;

	always_comb begin
		writeAllowed = 1'b0;
		case ({st.guardHigh, st.guardLow})
			2'b00: writeAllowed = writeLatchFlag;
			2'b01: writeAllowed = writeLatchFlag && guardEff;
			2'b10: writeAllowed = 1'b0;
			default: writeAllowed = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// state update
	always_comb begin
		next_st = st;
		next_st.accepted = 1'b0;
		next_st.rejected = 1'b0;
		next_st.loadPending = 1'b0;
		if (reload) begin
			// volatile copy from non-volatile bits
			next_st.cfg = CFG_RESET;
			next_st.fourLane = 1'b0;
			case ({nvGuardHigh, nvGuardLow})
				2'b00, 2'b01: begin
					next_st.guardHigh = nvGuardHigh;
					next_st.guardLow = nvGuardLow;
				end
				2'b10: begin
					next_st.guardHigh = 1'b0;
					next_st.guardLow = 1'b0;
				end
				default: begin
					next_st.guardHigh = permanentLockBit;
					next_st.guardLow = 1'b1;
				end
			endcase
		end else if (isStatusWrite) begin
			if (writeAllowed) begin
				next_st.accepted = 1'b1;
				if (cmdOpcode == OP_WR_SR1) begin
					next_st.guardLow = cmdData[SR1_GUARD_LOW_BIT];
				end else if (cmdOpcode == OP_WR_SR2) begin
					next_st.guardHigh = cmdData[SR2_GUARD_HIGH_BIT];
					next_st.fourLane = cmdData[SR2_FOUR_LANE_BIT];
				end else if (cmdOpcode == OP_WR_SR3) begin
					next_st.cfg = cmdData & CFG_WRITE_MASK;
				end
			end else begin
				next_st.rejected = 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			st <= '{guardHigh: 1'b0, guardLow: 1'b0, fourLane: 1'b0,
				cfg: CFG_RESET, accepted: 1'b0, rejected: 1'b0,
				loadPending: 1'b1};
		end else begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// block locks
	swp_block_locks #(.NUM(NUM), .AW(AW)) uLocks (
		.core_clk(core_clk),
		.resetn(resetn),
		.setAll(reload),
		.wrEn(isBlockCmd && !reload),
		.wrValue(cmdOpcode == OP_BLK_LOCK),
		.addr(cmdBlock),
		.rdData(blockLockRead),
		.locks(blockLocks)
	);

	////////////////////////////////////////////////////////////////////////
	// outputs
	assign statusGuardHigh = st.guardHigh;
	assign statusGuardLow = st.guardLow;
	assign fourLaneEnable = st.fourLane;
	assign pinDriveProtectConfig = st.cfg;
	assign outputStrength = st.cfg[CFG_STRENGTH_HI:CFG_STRENGTH_LO];
	assign protectSchemeSelect = st.cfg[CFG_SCHEME_BIT];
	assign pauseEnable = !st.fourLane && !st.cfg[CFG_PIN_FUNC_BIT];
	assign resetPinEnable = !st.fourLane && st.cfg[CFG_PIN_FUNC_BIT];
	assign writeAccepted = st.accepted;
	assign writeRejected = st.rejected;

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	soft_accept_a: assert property (isStatusWrite && !reload &&
		{st.guardHigh, st.guardLow} == 2'b00 && writeLatchFlag
		|=> writeAccepted) else $error("open write not accepted");
	pin_reject_a: assert property (isStatusWrite && !reload &&
		{st.guardHigh, st.guardLow} == 2'b01 && !guardPin && !st.fourLane
		|=> writeRejected && $stable(pinDriveProtectConfig))
		else $error("pin-guarded write not rejected");
	pin_accept_a: assert property (isStatusWrite && !reload &&
		{st.guardHigh, st.guardLow} == 2'b01 && guardPin && writeLatchFlag
		|=> writeAccepted) else $error("pin-high write not accepted");
	lockdown_a: assert property (isStatusWrite && !reload &&
		st.guardHigh |=> writeRejected && !writeAccepted)
		else $error("locked write accepted");
	otp_hold_a: assert property (statusGuardHigh && statusGuardLow &&
		permanentLockBit && !reload |=> statusGuardHigh && statusGuardLow)
		else $error("permanent guard changed");
	reload_map_a: assert property (reload && !nvGuardHigh
		|=> statusGuardHigh == $past(nvGuardHigh) &&
		statusGuardLow == $past(nvGuardLow))
		else $error("reload copy wrong");
	reload_ten_a: assert property (reload && nvGuardHigh &&
		!nvGuardLow |=> !statusGuardHigh && !statusGuardLow)
		else $error("reload 10 wrong");
	reload_lock_a: assert property (reload && nvGuardHigh &&
		nvGuardLow |=> statusGuardLow &&
		statusGuardHigh == $past(permanentLockBit))
		else $error("reload 11 wrong");
	discard_a: assert property (writeRejected |->
		$stable(pinDriveProtectConfig) && $stable(fourLaneEnable) &&
		$stable(statusGuardHigh)) else $error("rejected write changed bits");
	pin_func_a: assert property (fourLaneEnable |->
		!pauseEnable && !resetPinEnable) else $error("pin role in quad");
	locks_set_a: assert property (reload |=> &blockLocks)
		else $error("locks not set");

	accept_c: cover property (writeAccepted);
	reject_c: cover property (writeRejected);
	lock_cmd_c: cover property (isBlockCmd ##2 !blockLockRead);
	otp_c: cover property (statusGuardHigh && statusGuardLow);
endmodule : swp_write_protect

/* rtl/swp_pkg.sv */
// Purpose: constants for status register write protection
// Assumes: commands arrive already decoded from the serial front end
// Notes: offsets are bit positions inside the eight-bit registers
package swp_pkg;
	localparam logic [7:0] OP_WR_SR1 = 8'h01;
	localparam logic [7:0] OP_WR_SR2 = 8'h31;
	localparam logic [7:0] OP_WR_SR3 = 8'h11;
	localparam logic [7:0] OP_WR_SR4 = 8'h71;
	localparam logic [7:0] OP_BLK_LOCK = 8'h36;
	localparam logic [7:0] OP_BLK_UNLOCK = 8'h39;
	localparam int SR1_GUARD_LOW_BIT = 7;
	localparam int SR2_GUARD_HIGH_BIT = 0;
	localparam int SR2_FOUR_LANE_BIT = 1;
	localparam int CFG_PIN_FUNC_BIT = 7;
	localparam int CFG_STRENGTH_HI = 6;
	localparam int CFG_STRENGTH_LO = 5;
	localparam int CFG_SCHEME_BIT = 2;
	localparam logic [7:0] CFG_WRITE_MASK = 8'hE4;
	localparam logic [7:0] CFG_RESET = 8'h20;
	localparam int NUM_BLOCKS = 16;
endpackage : swp_pkg

/* rtl/swp_block_locks.sv */
// Purpose: per-block lock bits with registered read port
// Assumes: one lock or unlock per cycle
// Notes: setAll returns every lock to 1
module swp_block_locks #(
	parameter int NUM = swp_pkg::NUM_BLOCKS,
	parameter int AW = $clog2(swp_pkg::NUM_BLOCKS)
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic setAll,
	input wire logic wrEn,
	input wire logic wrValue,
	input wire logic [AW-1:0] addr,
	output logic rdData,
	output logic [NUM-1:0] locks
);
	import swp_pkg::*;

	typedef struct packed {
		logic [NUM-1:0] locks;
		logic rdData;
	} swp_lock_state_s;

	swp_lock_state_s st;
	swp_lock_state_s next_st;
	logic [NUM-1:0] nextLocks;

	////////////////////////////////////////////////////////////////////////
	// next value of each lock bit
	genvar g;
	generate
		for (g = 0; g < NUM; g++) begin : gLock
			assign nextLocks[g] = setAll ? 1'b1 :
				(wrEn && addr == AW'(g)) ? wrValue : st.locks[g];
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// state update
	always_comb begin
		next_st = st;
		next_st.locks = nextLocks;
		// read port shows the bit as it stood before this cycle's write
		next_st.rdData = st.locks[addr];
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			st <= '{locks: '1, rdData: 1'b1};
		end else begin
			st <= next_st;
		end
	end

	assign locks = st.locks;
	assign rdData = st.rdData;
endmodule : swp_block_locks

/* testbench/swp_host_model.sv */
// Purpose: host side issuing decoded status commands
// Assumes: one command per call
// Notes: idle lines carry the inverse of the last value
module swp_host_model (
	input wire logic core_clk,
	output logic cmdValid,
	output logic [7:0] cmdOpcode,
	output logic [7:0] cmdData,
	output logic [3:0] cmdBlock
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		cmdValid = 1'b0;
		cmdOpcode = 8'h00;
		cmdData = 8'h00;
		cmdBlock = 4'h0;
	end
	// lock 36h, unlock 39h, held for one edge
	task automatic send(input logic [7:0] op, input logic [7:0] d,
		input logic [3:0] b);
		@(negedge core_clk);
		cmdValid = 1'b1;
		cmdOpcode = op;
		cmdData = d;
		cmdBlock = b;
		@(negedge core_clk);
		cmdValid = 1'b0;
		cmdOpcode = ~op;
		cmdData = ~d;
		cmdBlock = ~b;
	endtask : send
endmodule : swp_host_model

/* testbench/tb_top.sv */
// Purpose: random self-checking bench for the write gate
// Assumes: nv bits and pins change only between commands
// Notes: reference model kept in ints
module tb_top;
	import swp_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic core_clk, resetn, devReset, nvGuardHigh, nvGuardLow;
	logic permanentLockBit, writeLatchFlag, guardPin, cmdValid;
	logic [7:0] cmdOpcode, cmdData, cfgOut, op, d;
	logic [3:0] cmdBlock;
	logic statusGuardHigh, statusGuardLow, fourLaneEnable;
	logic protectSchemeSelect, pauseEnable, resetPinEnable;
	logic writeAccepted, writeRejected, blockLockRead;
	logic [1:0] outputStrength;
	logic [15:0] blockLocks;
	logic [15:0] seed = 16'h6E2B;
	logic [7:0] ops[6] = '{8'h01, 8'h31, 8'h11, 8'h71, 8'h36, 8'h39};
	int n_errors = 0;
	int checked = 0;
	int gh, gl, fl, cfg, lk, acc, rej, lr;
	swp_host_model swp_host_model_inst (.core_clk, .cmdValid,
		.cmdOpcode, .cmdData, .cmdBlock);
	swp_write_protect swp_write_protect_inst (.core_clk, .resetn,
		.devReset, .nvGuardHigh, .nvGuardLow, .permanentLockBit,
		.writeLatchFlag, .guardPin, .cmdValid, .cmdOpcode, .cmdData,
		.cmdBlock, .statusGuardHigh, .statusGuardLow, .fourLaneEnable,
		.pinDriveProtectConfig(cfgOut), .outputStrength,
		.protectSchemeSelect, .pauseEnable, .resetPinEnable,
		.writeAccepted, .writeRejected, .blockLockRead, .blockLocks);
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	////////////////////////////////////////
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		checked++;
		if (g !== e) begin
			n_errors++;
			$display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
		end
	endtask : chk
	task automatic reload();
		gh = nvGuardHigh && nvGuardLow && permanentLockBit;
		gl = nvGuardLow;
		fl = 0;
		cfg = 8'h20;
		lk = 16'hFFFF;
		acc = 0;
		rej = 0;
	endtask : reload
	task automatic model(input logic [7:0] o, input logic [7:0] v,
		input logic [3:0] b);
		bit sw, ok;
		sw = o inside {OP_WR_SR1, OP_WR_SR2, OP_WR_SR3, OP_WR_SR4};
		ok = writeLatchFlag && !gh && !(gl && !guardPin && !fl);
		acc = sw && ok;
		rej = sw && !ok;
		if (acc && o == OP_WR_SR1) gl = v[7];
		if (acc && o == OP_WR_SR2) begin
			gh = v[0];
			fl = v[1];
		end
		if (acc && o == OP_WR_SR3) cfg = v & CFG_WRITE_MASK;
		if (cfg[2] && (o == OP_BLK_LOCK || o == OP_BLK_UNLOCK)) begin
			lk[b] = (o == OP_BLK_LOCK);
		end
	endtask : model
	task automatic compare_all();
		chk("accepted", acc, writeAccepted);
		chk("rejected", rej, writeRejected);
		chk("guards", {gh[0], gl[0]},
			{statusGuardHigh, statusGuardLow});
		chk("four lane", fl, fourLaneEnable);
		chk("config", cfg, cfgOut);
		chk("strength", cfg[6:5], outputStrength);
		chk("scheme", cfg[2], protectSchemeSelect);
		chk("pin role", {!fl && cfg[7], !fl && !cfg[7]},
			{resetPinEnable, pauseEnable});
		chk("locks", lk, blockLocks);
	endtask : compare_all
	task automatic final_report();
		$display("checks %0d errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : final_report
	initial begin
		resetn = 1'b0;
		devReset = 1'b0;
		{nvGuardHigh, nvGuardLow, permanentLockBit} = 3'h0;
		writeLatchFlag = 1'b1;
		guardPin = 1'b1;
		repeat (6) @(negedge core_clk);
		resetn = 1'b1;
		for (int i = 0; i < 600; i++) begin
			seed = lfsr(seed);
			writeLatchFlag = seed[0] | seed[1];
			guardPin = seed[2];
			if (seed[15:13] == 3'h0 || i == 0) begin
				{nvGuardHigh, nvGuardLow, permanentLockBit} = seed[5:3];
				if (seed[6] && i > 0) resetn = 1'b0;
				else devReset = 1'b1;
				@(negedge core_clk);
				resetn = 1'b1;
				devReset = 1'b0;
				if (!seed[6]) reload();
				else @(negedge core_clk);
				reload();
			end else begin
				op = ops[seed[10:8] % 6];
				seed = lfsr(seed);
				d = seed[7:0];
				lr = lk[seed[11:8]];
				model(op, d, seed[11:8]);
				swp_host_model_inst.send(op, d, seed[11:8]);
				chk("lock read", lr, blockLockRead);
			end
			compare_all();
		end
		final_report();
	end
endmodule : tb_top
